// ---- core/bmo_pkg.sv ----
// bmo_pkg: constants and types shared by the parallel BCD result port and its word buffer.
// assumes: one 200 MHz clock, and all pin inputs already synchronous to it.
// Functional notes
// - max, min and p-p data of every channel share one digit bus, chosen by select inputs
// - after a request the chosen channel's data is driven; ready ON marks it valid
// - all selects ON latches every channel, shows the first; each set strobe steps onward until the last channel is shown
// - six BCD digits weighted 1, 2, 4, 8; first digit is the least significant
// - output polarity selectable; positive logic shows bit 0 as ON, bit 1 as OFF
// - with no request, data outputs either hold the last word or go high impedance
// - sign output: under positive logic OFF is negative, ON is positive
// - alarm output OFF while any channel is in alarm, ON otherwise
// - alarm returns ON only after the cause is gone and that channel is reset
// - a data request arriving together with a serial output trigger is ignored
// - main display frozen from request until ready drops after the last word
// - front panel keys are rejected while the display is frozen
// - in start mode the pass/fail judgement is held for the whole transfer
// - sinking variant: ON is a low pin; sourcing variant: ON is a high pin
package bmo_pkg;

  localparam int NCH = 10;
  localparam int NDIG = 6;
  localparam int DIG_W = 4;
  localparam int DATA_W = NDIG * DIG_W;
  localparam int WORD_W = DATA_W + 1;
  localparam int NKEY = 8;
  localparam int BUF_DEPTH = 2;

  // select codes, bit 3 = fourth select input ... bit 0 = first, 1 = ON
  localparam logic [3:0] SEL_ALL = 4'hF;
  localparam logic [3:0] SEL_FIRST = 4'hE;
  localparam logic [3:0] SEL_LAST = 4'h5;
  localparam logic [3:0] LAST_CH = 4'(NCH - 1);

  localparam logic RST_OE_N = 1'b1;
  localparam logic RST_PIN = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_SHOW
  } bmo_state_e;

endpackage : bmo_pkg

// ---- core/bmo_buf2.sv ----
// bmo_buf2: two-entry word buffer with valid/ready on both sides and a flush.
// assumes: the filling side holds data stable while valid is high and ready is low.
`timescale 1ns/1ps
`default_nettype none

module bmo_buf2
  import bmo_pkg::*;
#(
  parameter int W = WORD_W
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);

  typedef struct packed {
    logic [BUF_DEPTH-1:0][W-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } bmo_buf_s;

  bmo_buf_s q;
  bmo_buf_s d;
  logic push;
  logic pop;

  assign inReady = (q.cnt != 2'(BUF_DEPTH));
  assign outValid = (q.cnt != 2'h0);
  assign outData = q.mem[q.rp];

  always_comb begin
    d = q;
    push = inValid & inReady;
    pop = outValid & outReady;
    if (flush) begin
      // a flush drops everything, including a word offered in the same cycle
      d.cnt = 2'h0;
      d.wp = 1'b0;
      d.rp = 1'b0;
    end else begin
      if (push) begin
        d.mem[q.wp] = inData;
        d.wp = ~q.wp;
      end
      if (pop) begin
        d.rp = ~q.rp;
      end
      d.cnt = 2'(q.cnt + {1'b0, push} - {1'b0, pop});
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : bmo_buf2

`default_nettype wire

// ---- core/bmo_port.sv ----
// bmo_port: parallel BCD result port with channel select, all-channel stepping and alarm.
// assumes: pin inputs are raw pin levels synchronous to sys_clk; channel values, alarm
// causes, reset inputs and key presses come from the unit's own logic, active high.
`timescale 1ns/1ps
`default_nettype none

module bmo_port
  import bmo_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic channelSelectBit1,
  input wire logic channelSelectBit2,
  input wire logic channelSelectBit3,
  input wire logic channelSelectBit4,
  input wire logic dataRequest,
  input wire logic setStrobe,
  input wire logic serialOutputTrigger,
  input wire logic sinkingVariant,
  input wire logic positiveLogic,
  input wire logic holdWhenIdle,
  input wire logic startHoldIsStart,
  input wire logic [NCH*DATA_W-1:0] chanDigits,
  input wire logic [NCH-1:0] chanNegative,
  input wire logic [NCH-1:0] chanAlarmCause,
  input wire logic [NCH-1:0] chanResetIn,
  input wire logic [3:0] displayedChan,
  input wire logic resetKey,
  input wire logic [NKEY-1:0] keyPress,
  output logic [NDIG-1:0] digitWeightOne,
  output logic [NDIG-1:0] digitWeightTwo,
  output logic [NDIG-1:0] digitWeightFour,
  output logic [NDIG-1:0] digitWeightEight,
  output logic digitOeN,
  output logic signOut,
  output logic signOeN,
  output logic readyOut,
  output logic alarmOut,
  output logic displayFrozen,
  output logic [NKEY-1:0] keyAccepted,
  output logic judgeHold
);

  typedef struct packed {
    bmo_state_e st;
    logic drqQ;
    logic setQ;
    logic allMode;
    logic blocked;
    logic [3:0] selIdx;
    logic filling;
    logic [3:0] fillIdx;
    logic [3:0] shownCnt;
    logic [WORD_W-1:0] shownWord;
    logic [NCH-1:0] alarm;
    logic [NCH-1:0][WORD_W-1:0] snap;
    logic [DATA_W-1:0] digPin;
    logic digOeN;
    logic signPin;
    logic signOeN;
    logic readyPin;
    logic alarmPin;
    logic frozen;
    logic [NKEY-1:0] keyAcc;
    logic judge;
  } bmo_port_s;

  bmo_port_s q;
  bmo_port_s d;

  logic [3:0] selCode;
  logic selValid;
  logic drqOn;
  logic setOn;
  logic setRise;
  logic active;
  logic flush;
  logic pushValid;
  logic pushReady;
  logic [WORD_W-1:0] pushData;
  logic popValid;
  logic popReady;
  logic [WORD_W-1:0] popData;
  logic [DATA_W-1:0] dataOn;
  logic signOn;
  logic readyOn;
  logic alarmOn;
  logic keysOk;
  logic chanClear;

  // pin level to logical ON and back
  function automatic logic pinOn(input logic pin, input logic sink);
    pinOn = sink ? ~pin : pin;
  endfunction : pinOn

  function automatic logic [WORD_W-1:0] liveWord(
    input logic [NCH*DATA_W-1:0] digits,
    input logic [NCH-1:0] neg,
    input logic [3:0] idx
  );
    liveWord = {neg[idx], digits[idx*DATA_W +: DATA_W]};
  endfunction : liveWord

  // select decode: the codes run downward from the first slot's A channel
  always_comb begin
    selCode = {pinOn(channelSelectBit4, sinkingVariant),
               pinOn(channelSelectBit3, sinkingVariant),
               pinOn(channelSelectBit2, sinkingVariant),
               pinOn(channelSelectBit1, sinkingVariant)};
    selValid = (selCode == SEL_ALL) ||
               ((selCode >= SEL_LAST) && (selCode <= SEL_FIRST));
    drqOn = pinOn(dataRequest, sinkingVariant);
    setOn = pinOn(setStrobe, sinkingVariant);
    setRise = setOn & ~q.setQ;
  end

  // the filler's valid and word index come from q only, so back-pressure never races the state update
  assign pushValid = q.filling;
  assign pushData = q.allMode ? q.snap[q.fillIdx] :
                    liveWord(chanDigits, chanNegative, q.selIdx);
  assign popReady = (q.st == ST_LOAD);

  bmo_buf2 #(
    .W(WORD_W)
  ) u_buf (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .flush(flush),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushData),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popData)
  );

  always_comb begin
    d = q;
    flush = 1'b0;
    d.drqQ = drqOn;
    d.setQ = setOn;

    // transfer sequencing
    case (q.st)
      ST_IDLE: begin
        if (!drqOn) begin
          d.blocked = 1'b0;
        end else if (!q.blocked) begin
          if (serialOutputTrigger || !selValid) begin
            // a clash with the serial trigger is refused until the request drops
            d.blocked = 1'b1;
          end else begin
            d.allMode = (selCode == SEL_ALL);
            d.selIdx = 4'(SEL_FIRST - selCode);
            d.filling = 1'b1;
            d.fillIdx = 4'h0;
            d.shownCnt = 4'h0;
            d.st = ST_LOAD;
            if (selCode == SEL_ALL) begin
              for (int i = 0; i < NCH; i++) begin
                d.snap[i] = liveWord(chanDigits, chanNegative, 4'(i));
              end
            end
          end
        end
      end
      ST_LOAD: begin
        if (popValid) begin
          d.shownWord = popData;
          d.st = ST_SHOW;
        end
      end
      ST_SHOW: begin
        // a strobe after the last channel has nothing left to show and is ignored
        if (q.allMode && setRise && (q.shownCnt != LAST_CH)) begin
          d.shownCnt = 4'(q.shownCnt + 4'h1);
          d.st = ST_LOAD;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    // filler: one word in single mode, every latched channel in order otherwise
    if (q.filling && pushReady) begin
      if (q.allMode && (q.fillIdx != LAST_CH)) begin
        d.fillIdx = 4'(q.fillIdx + 4'h1);
      end else begin
        d.filling = 1'b0;
      end
    end

    // withdrawing the request ends the transfer at once from any state
    if ((q.st != ST_IDLE) && !drqOn) begin
      d.st = ST_IDLE;
      d.filling = 1'b0;
      flush = 1'b1;
    end

    active = (d.st != ST_IDLE);
    readyOn = (d.st == ST_SHOW);
    d.frozen = active;
    keysOk = ~active;
    d.keyAcc = keyPress & {NKEY{keysOk}};
    d.judge = active & startHoldIsStart;

    // alarm latches: a cause sets, a reset clears only once the cause is gone
    for (int i = 0; i < NCH; i++) begin
      chanClear = chanResetIn[i] | (resetKey & keysOk & (displayedChan == 4'(i)));
      d.alarm[i] = chanAlarmCause[i] | (q.alarm[i] & ~chanClear);
    end
    alarmOn = ~|d.alarm;

    // logical levels to pin levels
    for (int b = 0; b < DATA_W; b++) begin
      dataOn[b] = positiveLogic ? ~d.shownWord[b] : d.shownWord[b];
      d.digPin[b] = pinOn(dataOn[b], sinkingVariant);
    end
    signOn = positiveLogic ? ~d.shownWord[WORD_W-1] : d.shownWord[WORD_W-1];
    d.signPin = pinOn(signOn, sinkingVariant);
    d.readyPin = pinOn(readyOn, sinkingVariant);
    d.alarmPin = pinOn(alarmOn, sinkingVariant);
    // in release mode the data lines float between transfers
    d.digOeN = ~(active | holdWhenIdle);
    d.signOeN = ~(active | holdWhenIdle);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.digOeN <= RST_OE_N;
      q.signOeN <= RST_OE_N;
      q.readyPin <= RST_PIN;
      q.alarmPin <= RST_PIN;
    end else begin
      q <= d;
    end
  end

  // digit k of the bus is bits 4k..4k+3 of the shown word, first digit least significant
  for (genvar k = 0; k < NDIG; k++) begin : g_digit
    assign digitWeightOne[k] = q.digPin[k*DIG_W];
    assign digitWeightTwo[k] = q.digPin[k*DIG_W+1];
    assign digitWeightFour[k] = q.digPin[k*DIG_W+2];
    assign digitWeightEight[k] = q.digPin[k*DIG_W+3];
  end

  assign digitOeN = q.digOeN;
  assign signOut = q.signPin;
  assign signOeN = q.signOeN;
  assign readyOut = q.readyPin;
  assign alarmOut = q.alarmPin;
  assign displayFrozen = q.frozen;
  assign keyAccepted = q.keyAcc;
  assign judgeHold = q.judge;

endmodule : bmo_port

`default_nettype wire

// ---- verif/bmo_host_model.sv ----
// bmo_host_model: controller that selects a channel, requests data and steps the set pin.
// assumes: bench commands change just after a rising edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none

module bmo_host_model (
  input wire logic sys_clk,
  input wire logic sinkingVariant,
  input wire logic [3:0] selCode,
  input wire logic reqOn,
  input wire logic stepOn,
  output logic [3:0] selPins,
  output logic dataRequest,
  output logic setStrobe
);
  // one driver per pin: the port holds its reset, so the pins only need to settle by release
  logic reqSeen;
  // pin = logical ON xor variant, so a sinking host pulls low for ON
  always @(posedge sys_clk) begin
    selPins <= selCode ^ {4{sinkingVariant}};
    reqSeen <= reqOn;
    // request lags the selects by a cycle so they are settled first
    dataRequest <= (reqOn & reqSeen) ^ sinkingVariant;
    setStrobe <= stepOn ^ sinkingVariant;
  end
endmodule : bmo_host_model

`default_nettype wire

// ---- verif/bmo_port_monitor.sv ----
// bmo_port_monitor: pin relations of the result port over time.
// assumes: variant and polarity inputs change only while reset is held.
`timescale 1ns/1ps
`default_nettype none

module bmo_port_monitor
  import bmo_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic dataRequest,
  input wire logic serialOutputTrigger,
  input wire logic sinkingVariant,
  input wire logic holdWhenIdle,
  input wire logic startHoldIsStart,
  input wire logic [NCH-1:0] chanAlarmCause,
  input wire logic digitOeN,
  input wire logic readyOut,
  input wire logic alarmOut,
  input wire logic displayFrozen,
  input wire logic [NKEY-1:0] keyAccepted,
  input wire logic judgeHold
);
  // pins still show reset levels at the first edge, so live_q masks it
  logic live_q;
  wire logic reqOn = dataRequest ^ sinkingVariant;
  wire logic rdyOn = readyOut ^ sinkingVariant;
  wire logic alarmOn = alarmOut ^ sinkingVariant;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) live_q <= 1'b0;
    else live_q <= 1'b1;
  end
  a_ready_drops: assert property (live_q && !reqOn |=> !rdyOn)
    else $error("ready on without request");
  a_ready_frozen: assert property (live_q && rdyOn |-> displayFrozen)
    else $error("ready on while not frozen");
  a_freeze_ends: assert property (!reqOn |=> !displayFrozen)
    else $error("frozen without request");
  a_keys_locked: assert property (displayFrozen |-> keyAccepted == '0)
    else $error("key accepted while frozen");
  a_judge_held: assert property (live_q |->
    judgeHold == (displayFrozen && startHoldIsStart))
    else $error("judge hold wrong");
  a_answer_time: assert property ($rose(displayFrozen) |-> !rdyOn ##1 !rdyOn ##[1:2] rdyOn)
    else $error("ready late or early");
  a_trigger_wins: assert property (reqOn && serialOutputTrigger && !displayFrozen
    |=> !displayFrozen)
    else $error("request taken with trigger");
  a_idle_oe: assert property (live_q && !reqOn && !displayFrozen
    |-> digitOeN == !holdWhenIdle)
    else $error("idle enable wrong");
  a_alarm_sets: assert property (|chanAlarmCause |=> !alarmOn)
    else $error("alarm not off");
  cover property ($rose(rdyOn));
  cover property ($fell(alarmOn));
  cover property (reqOn && serialOutputTrigger);
endmodule : bmo_port_monitor

bind bmo_port bmo_port_monitor u_mon (.sys_clk, .resetn, .dataRequest, .serialOutputTrigger,
  .sinkingVariant, .holdWhenIdle, .startHoldIsStart, .chanAlarmCause, .digitOeN, .readyOut,
  .alarmOut, .displayFrozen, .keyAccepted, .judgeHold);

`default_nettype wire

// ---- verif/testbench.sv ----
// testbench: host model drives the result port; each word shown is checked against a queue.
// assumes: package, design, host model and monitor compiled before it.
`timescale 1ns/1ps
`default_nettype none

module testbench
  import bmo_pkg::*;
;
  logic sys_clk = 1'b0, resetn = 1'b0, sinkingVariant = 1'b0, positiveLogic = 1'b0;
  logic holdWhenIdle = 1'b0, startHoldIsStart = 1'b0, serialOutputTrigger = 1'b0;
  logic resetKey = 1'b0, reqOn = 1'b0, stepOn = 1'b0, rdyQ = 1'b0;
  logic [3:0] selCode = 4'h0, displayedChan = 4'h2, selPins;
  logic dataRequest, setStrobe, signOut, signOeN, readyOut, alarmOut, digitOeN;
  logic displayFrozen, judgeHold;
  logic [NDIG-1:0] digitWeightOne, digitWeightTwo, digitWeightFour, digitWeightEight;
  logic [NCH*DATA_W-1:0] chanDigits = '0;
  logic [NCH-1:0] chanNegative = '0, chanAlarmCause = '0, chanResetIn = '0;
  logic [NKEY-1:0] keyPress = '0, keyAccepted;
  logic [WORD_W-1:0] expQ[$];
  logic [WORD_W-1:0] lastWord = '0;
  int failures = 0, n_compared = 0, seed = 32'h9AA0;
  wire logic rdy = readyOut ^ sinkingVariant;
  wire logic [WORD_W-1:0] shown = {signOut, digitWeightEight, digitWeightFour, digitWeightTwo,
    digitWeightOne};

  initial forever #2.5 sys_clk = ~sys_clk;

  bmo_host_model host (.sys_clk, .sinkingVariant, .selCode, .reqOn, .stepOn, .selPins,
    .dataRequest, .setStrobe);
  bmo_port DUT (.sys_clk, .resetn, .channelSelectBit1(selPins[0]), .channelSelectBit2(selPins[1]),
    .channelSelectBit3(selPins[2]), .channelSelectBit4(selPins[3]), .dataRequest, .setStrobe,
    .serialOutputTrigger, .sinkingVariant, .positiveLogic, .holdWhenIdle, .startHoldIsStart,
    .chanDigits, .chanNegative, .chanAlarmCause, .chanResetIn, .displayedChan, .resetKey,
    .keyPress, .digitWeightOne, .digitWeightTwo, .digitWeightFour, .digitWeightEight, .digitOeN,
    .signOut, .signOeN, .readyOut, .alarmOut, .displayFrozen, .keyAccepted, .judgeHold);

  function automatic logic [WORD_W-1:0] pinWord(input int ch);
    logic [WORD_W-1:0] w;
    for (int k = 0; k < DATA_W; k++) w[(k%DIG_W)*NDIG+k/DIG_W] = chanDigits[ch*DATA_W+k];
    w[DATA_W] = chanNegative[ch];
    return w ^ {WORD_W{positiveLogic ^ sinkingVariant}};
  endfunction : pinWord

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check

  task automatic stop_test();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic waitRdy(input logic want);
    int i;
    for (i = 0; i < 40 && rdy !== want; i++) @(negedge sys_clk);
    if (i == 40) begin
      failures++;
      stop_test();
    end
  endtask : waitRdy

  // live channel data is sampled at fill, so it stays put during the transfer
  task automatic xfer(input logic [3:0] code, input logic all);
    int i;
    @(posedge sys_clk);
    for (i = 0; i < NCH*NDIG; i++) begin
      chanDigits[i*DIG_W+:DIG_W] <= 4'($unsigned($random(seed)) % 10);
    end
    chanNegative <= NCH'($random(seed));
    keyPress <= NKEY'($random(seed)) | 8'h01;
    selCode <= code;
    reqOn <= 1'b1;
    @(posedge sys_clk);
    for (i = 0; i < (all ? NCH : 1); i++) expQ.push_back(pinWord(all ? i : 14 - code));
    waitRdy(1'b1);
    check("frozen", 1, 32'(displayFrozen));
    check("keys busy", 0, 32'(keyAccepted));
    check("judge", 32'(startHoldIsStart), 32'(judgeHold));
    // one extra step past the last channel must show nothing new
    for (i = 0; i < (all ? NCH : 0); i++) begin
      @(posedge sys_clk);
      stepOn <= 1'b1;
      @(posedge sys_clk);
      stepOn <= 1'b0;
      repeat (5) @(negedge sys_clk);
      waitRdy(1'b1);
    end
    // the word checker pops on the same negedge that ready is seen, so look a half cycle later
    @(posedge sys_clk);
    check("words left", 0, 32'(expQ.size()));
    reqOn <= 1'b0;
    waitRdy(1'b0);
    check("data oe", 32'(!holdWhenIdle), 32'(digitOeN));
    if (holdWhenIdle) check("held word", 32'(lastWord), 32'(shown));
    @(negedge sys_clk);
    check("keys idle", 32'(keyPress), 32'(keyAccepted));
  endtask : xfer

  always @(negedge sys_clk) begin
    if (resetn && rdy && !rdyQ) begin
      check("oe", 0, 32'({digitOeN, signOeN}));
      if (expQ.size() == 0) check("extra word", 0, 1);
      else begin
        lastWord <= expQ[0];
        check("word", 32'(expQ.pop_front()), 32'(shown));
      end
    end
    rdyQ <= rdy;
  end

  initial begin
    for (int v = 0; v < 4; v++) begin
      @(posedge sys_clk);
      resetn <= 1'b0;
      sinkingVariant <= v[0];
      positiveLogic <= v[1];
      holdWhenIdle <= v[0] ^ v[1];
      startHoldIsStart <= ~v[0];
      repeat (6) @(posedge sys_clk);
      resetn <= 1'b1;
      for (int c = SEL_LAST; c <= SEL_FIRST; c++) xfer(4'(c), 1'b0);
      xfer(SEL_ALL, 1'b1);
      // a code outside the table must never bring ready
      @(posedge sys_clk);
      selCode <= 4'h3;
      reqOn <= 1'b1;
      repeat (8) @(negedge sys_clk);
      check("ready bad sel", 0, 32'(rdy));
      @(posedge sys_clk);
      reqOn <= 1'b0;
      selCode <= SEL_FIRST;
      repeat (4) @(posedge sys_clk);
      @(posedge sys_clk);
      serialOutputTrigger <= 1'b1;
      reqOn <= 1'b1;
      repeat (8) @(negedge sys_clk);
      check("ready", 0, 32'(rdy));
      @(posedge sys_clk);
      reqOn <= 1'b0;
      chanAlarmCause <= 10'h004;
      @(posedge sys_clk);
      serialOutputTrigger <= 1'b0;
      chanAlarmCause <= '0;
      repeat (4) @(negedge sys_clk);
      check("alarm", 0, 32'(alarmOut ^ sinkingVariant));
      @(posedge sys_clk);
      if (v[0]) resetKey <= 1'b1;
      else chanResetIn <= 10'h004;
      @(posedge sys_clk);
      resetKey <= 1'b0;
      chanResetIn <= '0;
      repeat (3) @(negedge sys_clk);
      check("alarm", 1, 32'(alarmOut ^ sinkingVariant));
    end
    stop_test();
  end
endmodule : testbench

`default_nettype wire
